// *** src/buck_ctrl.sv ***
// control logic of an adaptive on-time synchronous buck controller
// Overview of operation
// - start an on-time pulse when feedback falls below the reference
// - on-time length comes from the estimator input, not from feedback
// - at on-time end, high-side gate off, then low-side gate on
// - off period never shorter than the 220 ns minimum off-time while enable stays high
// - feedback still low after minimum off-time starts next pulse at once
// - light-load variant turns both gates off on zero cross above reference
// - both gates off means low-power state; wake on low feedback with a pulse
// - reference ramps digitally from 0 to full over about 7 ms at startup
// - soft-start logic is disabled after the ramp reaches full value
// - overcurrent sampled only during low-side conduction after 150 ns blanking
// - current limit event recorded when limit comparator trips after blanking
// - eight consecutive current limit cycles enter hiccup mode
// - hiccup stops switching and restarts through a full soft-start ramp
// - continuous variant drops low-side gate on switch node above 12 mV
// - overvoltage trip stops switching at once with both gates off
// - overvoltage shutdown is latched until power-on reset
// - enable high allows operation, low shuts down with both gates off
`include "buck_ctrl_cfg.svh"
module buck_ctrl
  import buck_ctrl_pkg::*;
#(
  parameter bit LIGHT_LOAD = 1'b1,
  parameter int TON_W = 16,
  parameter int SOFT_START_CYCLES = `SOFT_START_CYC,
  parameter int HICCUP_OFF_CYCLES = `HICCUP_OFF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control pin
  input wire logic enable,
  // analog comparator outputs
  input wire logic feedbackLow,
  input wire logic zeroCross,
  input wire logic overcurrentTrip,
  input wire logic switchNodeHigh,
  input wire logic overvoltageTrip,
  // on-time estimator, in clock cycles
  input wire logic [TON_W-1:0] onTimeCycles,
  // gate drives
  output logic highSideGate,
  output logic lowSideGate,
  // status
  output logic [7:0] softStartRef,
  output logic softStartActive,
  output logic lowPower,
  output logic hiccupActive,
  output logic overvoltageLatched
);
  import buck_ctrl_pkg::*;

  localparam int TW = 24;
  localparam logic [TW-1:0] MINOFF = TW'(`MIN_OFF_CYC);
  localparam logic [TW-1:0] BLANK = TW'(`BLANK_CYC);
  localparam logic [TW-1:0] HOFF = TW'(HICCUP_OFF_CYCLES);
  localparam int STEP = (SOFT_START_CYCLES / 255) > 0 ? SOFT_START_CYCLES / 255 : 1;
  localparam logic [TW-1:0] RSTEP = TW'(STEP - 1);

  // synchronisers for pin-level inputs
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic en, fbLow, zc, ocTrip, swHigh, ovTrip;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
    end else begin
      syncA_q <= {enable, feedbackLow, zeroCross, overcurrentTrip, switchNodeHigh,
                  overvoltageTrip};
      syncB_q <= syncA_q;
    end
  end
  assign {en, fbLow, zc, ocTrip, swHigh, ovTrip} = syncB_q;

  phase_t state_q;
  phase_t state_d;
  logic onDone, offDone, blankDone, rampTick, hicDone;
  logic loadOn, loadOff, loadBlank, loadRamp, loadHic;
  logic [7:0] ref_q;
  logic ssRun_q;
  logic [3:0] limCnt_q;
  logic limSeen_q;
  logic negOff_q;
  logic ovLatch_q;
  logic startRamp;

  // one timer per concern, sharing one counter module
  cycle_timer #(.W(TW)) u_on (
    .clk(clk), .rst(rst), .load(loadOn),
    .count(TW'(onTimeCycles)), .done(onDone));
  cycle_timer #(.W(TW)) u_off (
    .clk(clk), .rst(rst), .load(loadOff), .count(MINOFF), .done(offDone));
  cycle_timer #(.W(TW)) u_blank (
    .clk(clk), .rst(rst), .load(loadBlank), .count(BLANK), .done(blankDone));
  cycle_timer #(.W(TW)) u_ramp (
    .clk(clk), .rst(rst), .load(loadRamp), .count(RSTEP), .done(rampTick));
  cycle_timer #(.W(TW)) u_hic (
    .clk(clk), .rst(rst), .load(loadHic), .count(HOFF), .done(hicDone));

  logic rampFull;
  assign rampFull = (ref_q == `REF_FULL);
  // ramp must climb past zero before switching, so hold the loop off until first step
  logic canSwitch;
  assign canSwitch = !ssRun_q || (ref_q != 8'h00);

  // next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (en && canSwitch && fbLow) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (onDone) begin
          state_d = ST_MINOFF;
        end
      end
      ST_MINOFF: begin
        // back-to-back pulses never visit the low state, so the limit is checked here too
        if (limCnt_q == 4'(`HICCUP_LIMIT)) begin
          state_d = ST_HICCUP;
        end else if (offDone) begin
          state_d = fbLow ? ST_ON : ST_LOW;
        end
      end
      ST_LOW: begin
        if (limCnt_q == 4'(`HICCUP_LIMIT)) begin
          state_d = ST_HICCUP;
        end else if (fbLow) begin
          state_d = ST_ON;
        end else if (LIGHT_LOAD && zc) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fbLow) begin
          state_d = ST_ON;
        end
      end
      ST_HICCUP: begin
        if (hicDone && !loadHic) begin
          state_d = ST_OFF;
        end
      end
      ST_OVLATCH: begin
        state_d = ST_OVLATCH;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (state_q != ST_OVLATCH && ovTrip) begin
      state_d = ST_OVLATCH;
    end else if (state_q != ST_OVLATCH && !en) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  logic enterOn, enterLow;
  assign enterOn = (state_d == ST_ON) && (state_q != ST_ON);
  assign enterLow = (state_d == ST_MINOFF) && (state_q == ST_ON);
  assign loadOn = enterOn;
  assign loadOff = enterLow;
  assign loadBlank = enterLow;
  assign loadHic = (state_d == ST_HICCUP) && (state_q != ST_HICCUP);
  assign startRamp = (state_q == ST_HICCUP) && (state_d == ST_OFF);
  assign loadRamp = rampTick && ssRun_q;

  // soft-start reference ramp
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_q <= 8'h00;
      ssRun_q <= 1'b1;
    end else if (startRamp || !en) begin
      ref_q <= 8'h00;
      ssRun_q <= 1'b1;
    end else if (ssRun_q && rampTick) begin
      if (rampFull) begin
        ssRun_q <= 1'b0;
      end else begin
        ref_q <= ref_q + 8'h01;
      end
    end
  end

  // current limit sampling and consecutive count
  logic lowCond;
  assign lowCond = (state_q == ST_MINOFF) || (state_q == ST_LOW);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      limSeen_q <= 1'b0;
    end else if (enterLow) begin
      limSeen_q <= 1'b0;
    end else if (lowCond && lowSideGate && blankDone && ocTrip) begin
      limSeen_q <= 1'b1;
    end
  end

  // a cycle ends when the next on-time starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      limCnt_q <= 4'h0;
    end else if (loadHic || !en) begin
      limCnt_q <= 4'h0;
    end else if (lowCond && lowSideGate && blankDone && ocTrip && !limSeen_q) begin
      limCnt_q <= limCnt_q + 4'h1;
    end else if (enterOn && !limSeen_q) begin
      limCnt_q <= 4'h0;
    end
  end

  // negative current limit in continuous variant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      negOff_q <= 1'b0;
    end else if (enterOn || !lowCond) begin
      negOff_q <= 1'b0;
    end else if (!LIGHT_LOAD && swHigh) begin
      negOff_q <= 1'b1;
    end
  end

  // overvoltage latch, cleared only by power-on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovLatch_q <= 1'b0;
    end else if (ovTrip) begin
      ovLatch_q <= 1'b1;
    end
  end

  // gate drives are registered so they never glitch on comparator edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      highSideGate <= 1'b0;
      lowSideGate <= 1'b0;
    end else begin
      highSideGate <= (state_d == ST_ON) && !enterLow;
      lowSideGate <= ((state_d == ST_MINOFF) || (state_d == ST_LOW)) && (state_q != ST_ON)
                     && !negOff_q && !(!LIGHT_LOAD && swHigh && lowCond);
    end
  end

  assign softStartRef = ref_q;
  assign softStartActive = ssRun_q;
  assign lowPower = (state_q == ST_IDLE);
  assign hiccupActive = (state_q == ST_HICCUP);
  assign overvoltageLatched = ovLatch_q;

  property p_no_overlap;
    @(posedge clk) disable iff (rst) !(highSideGate && lowSideGate);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");

  property p_minoff;
    @(posedge clk) disable iff (rst)
      $fell(highSideGate) |-> !highSideGate [*8];
  endproperty
  a_minoff: assert property (p_minoff) else $error("off time too short");

  property p_ov_off;
    @(posedge clk) disable iff (rst)
      ovTrip |=> ##1 (!highSideGate && !lowSideGate);
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("gates on after overvoltage");

  property p_ov_latch;
    @(posedge clk) disable iff (rst)
      ovLatch_q |=> ovLatch_q && state_q == ST_OVLATCH;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("overvoltage latch lost");

  property p_enable_off;
    @(posedge clk) disable iff (rst)
      !en |=> ##1 (!highSideGate && !lowSideGate);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("gates on while disabled");

  property p_hiccup;
    @(posedge clk) disable iff (rst)
      (lowCond && limCnt_q == 4'(`HICCUP_LIMIT) && en && !ovTrip)
        |=> state_q == ST_HICCUP;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("hiccup not entered");

  property p_hiccup_quiet;
    @(posedge clk) disable iff (rst)
      state_q == ST_HICCUP |=> !highSideGate;
  endproperty
  a_hiccup_quiet: assert property (p_hiccup_quiet) else $error("switching in hiccup");

  property p_ramp_mono;
    @(posedge clk) disable iff (rst)
      (ssRun_q && en && !startRamp) |=> ref_q >= $past(ref_q);
  endproperty
  a_ramp_mono: assert property (p_ramp_mono) else $error("reference ramp fell");

  property p_ss_off;
    @(posedge clk) disable iff (rst)
      (!ssRun_q && en && !startRamp) |=> !ssRun_q && rampFull;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("soft-start restarted");

  property p_idle_gates;
    @(posedge clk) disable iff (rst)
      (state_q == ST_IDLE) ##1 (state_q == ST_IDLE) |-> !highSideGate && !lowSideGate;
  endproperty
  a_idle_gates: assert property (p_idle_gates) else $error("gates on in idle");

  property p_neg_limit;
    @(posedge clk) disable iff (rst)
      (!LIGHT_LOAD && swHigh && lowCond) |=> !lowSideGate;
  endproperty
  a_neg_limit: assert property (p_neg_limit) else $error("low side on above limit");

  property p_blank_sample;
    @(posedge clk) disable iff (rst)
      $rose(limSeen_q) |-> $past(lowCond && lowSideGate && blankDone);
  endproperty
  a_blank_sample: assert property (p_blank_sample) else $error("limit taken in blanking");

  property p_wake;
    @(posedge clk) disable iff (rst)
      (state_q == ST_IDLE && fbLow && en && !ovTrip) |=> highSideGate;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");

  // a clean cycle must not leave a stale count that could add up to a false hiccup
  property p_cnt_clear;
    @(posedge clk) disable iff (rst)
      (enterOn && !limSeen_q && !(lowCond && lowSideGate && blankDone && ocTrip))
        |=> limCnt_q == 4'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("limit count not cleared");
endmodule : buck_ctrl

// *** src/buck_ctrl_cfg.svh ***
// timing and count constants for the on-time buck control
`ifndef BUCK_CTRL_CFG_SVH
`define BUCK_CTRL_CFG_SVH
`define CLK_PERIOD_NS 8
`define MIN_OFF_NS 220
`define MIN_OFF_CYC ((`MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_NS 150
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFT_START_NS 7000000
`define SOFT_START_CYC (`SOFT_START_NS / `CLK_PERIOD_NS)
`define HICCUP_LIMIT 8
`define HICCUP_OFF_CYC 4096
`define REF_FULL 8'hFF
`endif

// *** src/buck_ctrl_pkg.sv ***
// types for the on-time buck control
package buck_ctrl_pkg;
  typedef enum {
    ST_OFF,
    ST_ON,
    ST_MINOFF,
    ST_LOW,
    ST_IDLE,
    ST_HICCUP,
    ST_OVLATCH
  } phase_t;
endpackage : buck_ctrl_pkg

// *** src/cycle_timer.sv ***
// loadable down counter with done flag
module cycle_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  // status
  output logic done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // done ignores load so a caller may reload from done without a combinational loop
  assign done = (cnt_q == '0);
endmodule : cycle_timer

// *** tb/power_stage_model.sv ***
// behavioural power stage and comparators facing the buck control
module power_stage_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // gate drives
  input wire logic highSideGate,
  input wire logic lowSideGate,
  // scenario controls
  input wire logic [3:0] loadLevel,
  input wire logic shorted,
  // comparator outputs
  output logic feedbackLow,
  output logic zeroCross,
  output logic overcurrentTrip,
  output logic switchNodeHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  int vOut;
  int vNext;
  // crude charge model: the high side adds charge, the load drains it every cycle
  assign vNext = vOut + (highSideGate ? 4 : 0) - int'(loadLevel);
  // moves on the falling edge so the control never samples a changing level
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      vOut <= 0;
    end else begin
      vOut <= (vNext > 0) ? vNext : 0;
    end
  end
  always @(negedge clk) begin
    feedbackLow <= (vOut < 1000);
    // light load lets inductor current reverse as soon as the low side turns on
    zeroCross <= lowSideGate && (loadLevel < 4'h2);
    switchNodeHigh <= lowSideGate && (loadLevel < 4'h2);
    overcurrentTrip <= lowSideGate && shorted;
  end
endmodule : power_stage_model

// *** tb/testbench.sv ***
// self-checking bench for the on-time buck control
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b1;
  logic overvoltageTrip = 1'b0;
  logic [15:0] onTimeCycles = 16'h0028;
  logic [3:0] loadLevel = 4'h8;
  logic shorted = 1'b0;
  logic feedbackLow, zeroCross, overcurrentTrip, switchNodeHigh;
  logic highSideGate, lowSideGate, softStartActive, lowPower;
  logic hiccupActive, overvoltageLatched;
  logic [7:0] softStartRef;
  int num_errors = 0;
  int n_checks = 0;
  int i, n, m;
  always #4 clk = ~clk;
  // short ramp and hiccup counts keep the run brief
  buck_ctrl #(.LIGHT_LOAD(1'b1), .TON_W(16), .SOFT_START_CYCLES(2550),
    .HICCUP_OFF_CYCLES(64)) dut (.clk(clk), .rst(rst), .enable(enable),
    .feedbackLow(feedbackLow), .zeroCross(zeroCross), .overcurrentTrip(overcurrentTrip),
    .switchNodeHigh(switchNodeHigh), .overvoltageTrip(overvoltageTrip),
    .onTimeCycles(onTimeCycles), .highSideGate(highSideGate), .lowSideGate(lowSideGate),
    .softStartRef(softStartRef), .softStartActive(softStartActive), .lowPower(lowPower),
    .hiccupActive(hiccupActive), .overvoltageLatched(overvoltageLatched));
  power_stage_model stage (.clk(clk), .rst(rst), .highSideGate(highSideGate),
    .lowSideGate(lowSideGate), .loadLevel(loadLevel), .shorted(shorted),
    .feedbackLow(feedbackLow), .zeroCross(zeroCross), .overcurrentTrip(overcurrentTrip),
    .switchNodeHigh(switchNodeHigh));
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // a wait that ran out of its bound ends the run at once
  task must(input logic ok, input string msg);
    check(ok, 1'b1, msg);
    if (ok !== 1'b1) test_done();
  endtask : must
  task t_startup;
    check({highSideGate, lowSideGate, softStartActive}, 3'b001, "reset outputs");
    @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 4000 && softStartRef !== 8'hFF; n++) @(negedge clk);
    must(softStartRef === 8'hFF, "ramp end");
    check(n >= 2500 && n <= 2600, 1'b1, "ramp length");
    repeat (12) @(negedge clk);
    check(softStartActive, 1'b0, "ramp logic off");
    $display("end startup");
  endtask : t_startup
  task t_pulse;
    for (int k = 0; k < 2; k++) begin
      onTimeCycles = k ? 16'h0014 : 16'h0028;
      for (i = 0; i < 300 && highSideGate !== 1'b0; i++) @(negedge clk);
      for (i = 0; i < 300 && highSideGate !== 1'b1; i++) @(negedge clk);
      must(highSideGate === 1'b1, "pulse start");
      for (n = 0; n < 300 && highSideGate === 1'b1; n++) @(negedge clk);
      check(n >= onTimeCycles && n <= onTimeCycles + 2, 1'b1, "on length");
      check(lowSideGate, 1'b0, "dead cycle");
      @(negedge clk);
      check(lowSideGate, 1'b1, "low side on");
      for (m = 1; m < 300 && highSideGate !== 1'b1; m++) @(negedge clk);
      check(m >= 28, 1'b1, "minimum off");
      check(m <= 31, 1'b1, "back to back");
    end
    $display("end pulse");
  endtask : t_pulse
  task t_light;
    loadLevel = 4'h1;
    for (i = 0; i < 5000 && lowPower !== 1'b1; i++) @(negedge clk);
    must(lowPower === 1'b1, "idle entry");
    check({highSideGate, lowSideGate}, 2'b00, "idle gates");
    for (i = 0; i < 3000 && highSideGate !== 1'b1; i++) @(negedge clk);
    must(highSideGate === 1'b1, "wake pulse");
    check(lowPower, 1'b0, "awake");
    $display("end light");
  endtask : t_light
  task t_hiccup;
    loadLevel = 4'h8;
    shorted = 1'b1;
    for (i = 0; i < 3000 && hiccupActive !== 1'b1; i++) @(negedge clk);
    must(hiccupActive === 1'b1, "hiccup entry");
    check({highSideGate, lowSideGate}, 2'b00, "hiccup gates");
    shorted = 1'b0;
    for (i = 0; i < 300 && hiccupActive !== 1'b0; i++) @(negedge clk);
    must(hiccupActive === 1'b0, "hiccup exit");
    check(softStartRef <= 8'h01 && softStartActive, 1'b1, "ramp restart");
    $display("end hiccup");
  endtask : t_hiccup
  task t_enable;
    enable = 1'b0;
    repeat (4) @(negedge clk);
    check({highSideGate, lowSideGate, softStartRef}, 10'h000, "disabled");
    enable = 1'b1;
    for (i = 0; i < 300 && highSideGate !== 1'b1; i++) @(negedge clk);
    must(highSideGate === 1'b1, "resume");
    $display("end enable");
  endtask : t_enable
  task t_ovp;
    overvoltageTrip = 1'b1;
    repeat (5) @(negedge clk);
    check({highSideGate, lowSideGate, overvoltageLatched}, 3'b001, "trip");
    overvoltageTrip = 1'b0;
    repeat (200) @(negedge clk);
    check({highSideGate, lowSideGate, overvoltageLatched}, 3'b001, "latched");
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(overvoltageLatched, 1'b0, "power cycle clears");
    $display("end ovp");
  endtask : t_ovp
  initial begin
    repeat (20) @(negedge clk);
    t_startup();
    t_pulse();
    t_light();
    t_hiccup();
    t_enable();
    t_ovp();
    test_done();
  end
endmodule : testbench
